// File: core/pm_power_ctrl.sv
`timescale 1ns/1ns
module pm_power_ctrl #(
   parameter int CHANNELS = 8,
   parameter int LOAD_LIMIT = pm_pkg::LOAD_LIMIT_CYCLES,
   parameter logic [15:0] VENDOR_DEFAULT = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_DEFAULT = 16'h5678, // arbitrary value
   parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // configuration space access
   input wire logic i_cfg_req,
   input wire logic i_cfg_write,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   // software initialization indication (memory space enabled)
   input wire logic i_sw_init_done,
   // functional gating toward the rest of the device
   output logic o_mem_respond_en,
   output logic o_irq_en,
   output logic o_pci_drive_en,
   output logic o_rx_enable,
   output logic o_d3hot,
   // wake sources
   input wire logic [CHANNELS-1:0] i_rx,
   input wire logic [CHANNELS*pm_pkg::MSR_DELTA_BITS-1:0] i_msr_delta,
   // wake output pin, open drain
   output logic o_pme_out,
   output logic o_pme_oe,
   // eeprom word reader
   input wire logic i_eeprom_chip_select,
   output logic o_ee_req,
   output logic [2:0] o_ee_addr,
   input wire logic i_ee_valid,
   input wire logic [pm_pkg::EE_WORD_BITS-1:0] i_ee_data,
   output logic o_load_busy
);
   import pm_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   localparam int CNT_W = $clog2(LOAD_LIMIT + 1);
   localparam logic [CNT_W-1:0] LOAD_LAST = CNT_W'(LOAD_LIMIT - 1);

   typedef struct packed {
      pwr_state_e pwr;
      logic [1:0] ps_field;
      logic pme_en;
      logic pme_status;
      logic [15:0] vendor;
      logic [15:0] device;
      logic [23:0] class_code;
      logic [15:0] subsys_vendor;
      logic [15:0] subsys;
      logic [31:0] user;
      load_state_e ld;
      logic [2:0] ld_idx;
      logic [CNT_W-1:0] ld_cnt;
      logic ack;
      logic [31:0] rdata;
   } ctrl_s;

   ctrl_s state_q;
   ctrl_s state_d;
   logic wake_event;
   logic take;
   logic csr_write;
   logic [31:0] read_word;

   // ****************************************************************
   // wake event detection
   // ****************************************************************
   wake_detect #(
      .CHANNELS(CHANNELS)
   ) u_wake (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_rx(i_rx),
      .i_msr_delta(i_msr_delta),
      .o_wake_event(wake_event)
   );

   // ****************************************************************
   // configuration access decode
   // ****************************************************************

   // accept one request per ack; config space is held off while loading
   assign take = i_cfg_req & ~state_q.ack & (state_q.ld == LD_DONE);
   assign csr_write = take & i_cfg_write & (i_cfg_addr == OFF_PM_CSR);

   // read mux over the implemented dwords, all others read zero
   always_comb begin
      read_word = 32'h00000000;
      unique case (i_cfg_addr)
         OFF_ID: begin
            read_word = {state_q.device, state_q.vendor};
         end
         OFF_CLASS: begin
            read_word = {state_q.class_code, REVISION};
         end
         OFF_SUBSYS: begin
            read_word = {state_q.subsys, state_q.subsys_vendor};
         end
         OFF_CAP_PTR: begin
            read_word = {24'h000000, CAP_PTR_VALUE};
         end
         OFF_PM_CAP: begin
            read_word = PM_CAP_VALUE;
         end
         OFF_PM_CSR: begin
            // reserved bits 14:9 and 7:2 read zero
            read_word[PS_LSB +: 2] = state_q.ps_field;
            read_word[PME_EN_BIT] = state_q.pme_en;
            read_word[PME_STATUS_BIT] = state_q.pme_status;
         end
         OFF_USER: begin
            read_word = state_q.user;
         end
         default: begin
            read_word = 32'h00000000;
         end
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      state_d.ack = take;
      if (take && !i_cfg_write) begin
         state_d.rdata = read_word;
      end

      // wake status: set by any event in D3hot regardless of enable,
      // cleared by writing one; a set in the same cycle wins
      if (csr_write && i_cfg_be[1] && i_cfg_wdata[PME_STATUS_BIT]) begin
         state_d.pme_status = 1'b0;
      end
      if (wake_event && state_q.pwr == PWR_D3_HOT) begin
         state_d.pme_status = 1'b1;
      end

      // wake enable, low-order bit of the upper control byte
      if (csr_write && i_cfg_be[1]) begin
         state_d.pme_en = i_cfg_wdata[PME_EN_BIT];
      end

      // power state machine; registers are untouched on any transition
      unique case (state_q.pwr)
         PWR_D0_UNINIT: begin
            if (i_sw_init_done) begin
               state_d.pwr = PWR_D0_ACTIVE;
            end
         end
         PWR_D0_ACTIVE: begin
            if (i_sw_init_done == 1'b0) begin
               state_d.pwr = PWR_D0_UNINIT;
            end
         end
         PWR_D3_HOT: begin
            // context kept as is while here
            state_d.pwr = PWR_D3_HOT;
         end
         PWR_RETURN: begin
            // one cycle with drivers off, then active
            state_d.pwr = PWR_D0_ACTIVE;
         end
      endcase

      // power-state field writes; unsupported codes are ignored
      if (csr_write && i_cfg_be[0]) begin
         if (i_cfg_wdata[PS_LSB +: 2] == PS_D3HOT &&
            (state_q.pwr == PWR_D0_UNINIT || state_q.pwr == PWR_D0_ACTIVE)) begin
            state_d.pwr = PWR_D3_HOT;
            state_d.ps_field = PS_D3HOT;
         end else if (i_cfg_wdata[PS_LSB +: 2] == PS_D0 &&
            state_q.pwr == PWR_D3_HOT) begin
            state_d.pwr = PWR_RETURN;
            state_d.ps_field = PS_D0;
         end
      end

      // eeprom download sequencer
      unique case (state_q.ld)
         LD_STRAP: begin
            // chip select level caught on the first edge after release
            state_d.ld = i_eeprom_chip_select ? LD_FETCH : LD_DONE;
            state_d.ld_cnt = CNT_W'(1);
         end
         LD_FETCH: begin
            state_d.ld_cnt = state_q.ld_cnt + CNT_W'(1);
            if (i_ee_valid) begin
               // fixed word map, each eeprom word is 16 bits
               unique case (state_q.ld_idx)
                  3'h0: state_d.vendor = i_ee_data;
                  3'h1: state_d.device = i_ee_data;
                  3'h2: state_d.class_code[7:0] = i_ee_data[15:8];
                  3'h3: state_d.class_code[23:8] = i_ee_data;
                  3'h4: state_d.subsys_vendor = i_ee_data;
                  3'h5: state_d.subsys = i_ee_data;
                  3'h6: state_d.user[15:0] = i_ee_data;
                  3'h7: state_d.user[31:16] = i_ee_data;
               endcase
               state_d.ld_idx = state_q.ld_idx + 3'h1;
               if (state_q.ld_idx == 3'(EE_WORDS - 1)) begin
                  state_d.ld = LD_DONE;
               end
            end
            // give up rather than overrun the download limit
            if (state_q.ld_cnt >= LOAD_LAST) begin
               state_d.ld = LD_DONE;
            end
         end
         LD_DONE: begin
            state_d.ld = LD_DONE;
         end
         default: begin
            state_d.ld = LD_DONE;
         end
      endcase
   end

   // ****************************************************************
   // registers; every reset restores the power-on defaults
   // ****************************************************************
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state_q.pwr <= PWR_D0_UNINIT;
         state_q.ps_field <= PS_RESET;
         state_q.pme_en <= PME_EN_RESET;
         state_q.pme_status <= 1'b0;
         state_q.vendor <= VENDOR_DEFAULT;
         state_q.device <= DEVICE_DEFAULT;
         state_q.class_code <= CLASS_RESET;
         state_q.subsys_vendor <= SUBSYS_RESET;
         state_q.subsys <= SUBSYS_RESET;
         state_q.user <= USER_RESET;
         state_q.ld <= LD_STRAP;
         state_q.ld_idx <= 3'h0;
         state_q.ld_cnt <= '0;
         state_q.ack <= 1'b0;
         state_q.rdata <= 32'h00000000;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************

   // configuration answer
   assign o_cfg_ack = state_q.ack;
   assign o_cfg_rdata = state_q.rdata;

   // memory space and interrupts only while fully active
   assign o_mem_respond_en = (state_q.pwr == PWR_D0_ACTIVE);
   assign o_irq_en = (state_q.pwr == PWR_D0_ACTIVE);
   assign o_d3hot = (state_q.pwr == PWR_D3_HOT);

   // bus drivers off while returning from D3hot
   assign o_pci_drive_en = (state_q.pwr != PWR_RETURN);

   // receivers and flow control never gated by power state
   assign o_rx_enable = 1'b1;

   // wake pin pulled low only in D3hot with enable and pending status
   assign o_pme_out = 1'b0;
   assign o_pme_oe = (state_q.pwr == PWR_D3_HOT) & state_q.pme_en &
      state_q.pme_status;

   // eeprom word requests
   assign o_ee_req = (state_q.ld == LD_FETCH);
   assign o_ee_addr = state_q.ld_idx;
   assign o_load_busy = (state_q.ld != LD_DONE);
endmodule : pm_power_ctrl

// File: shared/pm_pkg.sv
// Behaviour
// - support D0, D3hot, D3cold; wake only in D3hot
// - entering D0 starts in D0 uninitialized
// - D0 active answers everything, may interrupt
// - writing D3hot code to bits 1:0 enters D3hot
// - D3hot: config accesses only, no interrupts
// - D3hot keeps serial receive and flow control running
// - D3hot with enable: start bit or delta raises wake
// - wake sets status always; host clears by one
// - D0 write from D3hot enters active, keeps registers
// - bus drivers off during D3hot to D0 transition
// - D3hot preserves configuration and functional context
// - D3cold loses context, never raises wake output
// - reset after power returns restores all defaults
// - 32-bit user register at 0x48, eeprom-only
// - eeprom organized as 16-bit words
// - download after reset only if chip select high
// - download finishes within 2^16 clocks of release
// - eeprom words 0..7 map to fixed config words
// - word for 0x08 uses only upper byte
// - enable and state fields reset zero, 7:2 zero
// - control/status in low half of 0x44, status bit 15
package pm_pkg;
   // ****************************************************************
   // configuration space offsets (byte addresses of dwords)
   // ****************************************************************
   localparam logic [7:0] OFF_ID = 8'h00;
   localparam logic [7:0] OFF_CLASS = 8'h08;
   localparam logic [7:0] OFF_SUBSYS = 8'h2C;
   localparam logic [7:0] OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] OFF_PM_CAP = 8'h40;
   localparam logic [7:0] OFF_PM_CSR = 8'h44;
   localparam logic [7:0] OFF_USER = 8'h48;

   // ****************************************************************
   // control/status field layout and reset values
   // ****************************************************************
   localparam int PS_LSB = 0;
   localparam int PME_EN_BIT = 8;
   localparam int PME_STATUS_BIT = 15;
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D3HOT = 2'h3;
   localparam logic [1:0] PS_RESET = 2'h0;
   localparam logic PME_EN_RESET = 1'b0;
   localparam logic [31:0] USER_RESET = 32'h00000000;
   localparam logic [23:0] CLASS_RESET = 24'h070002;
   localparam logic [31:0] PM_CAP_VALUE = 32'h420A0001;
   localparam logic [7:0] CAP_PTR_VALUE = 8'h40;
   localparam logic [15:0] SUBSYS_RESET = 16'h0000;

   // ****************************************************************
   // eeprom layout and download timing
   // ****************************************************************
   localparam int EE_WORD_BITS = 16;
   localparam int EE_WORDS = 8;
   localparam int LOAD_LIMIT_CYCLES = 65536;
   localparam int MSR_DELTA_BITS = 4;

   // ****************************************************************
   // state types
   // ****************************************************************
   typedef enum logic [3:0] {
      PWR_D0_UNINIT = 4'h1,
      PWR_D0_ACTIVE = 4'h2,
      PWR_D3_HOT = 4'h4,
      PWR_RETURN = 4'h8
   } pwr_state_e;

   typedef enum logic [2:0] {
      LD_STRAP = 3'h1,
      LD_FETCH = 3'h2,
      LD_DONE = 3'h4
   } load_state_e;
endpackage : pm_pkg

// File: core/wake_detect.sv
`timescale 1ns/1ns
module wake_detect #(
   parameter int CHANNELS = 8
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // serial receive lines and modem delta bits per channel
   input wire logic [CHANNELS-1:0] i_rx,
   input wire logic [CHANNELS*pm_pkg::MSR_DELTA_BITS-1:0] i_msr_delta,
   // one-cycle wake event
   output logic o_wake_event
);
   import pm_pkg::*;

   typedef struct packed {
      logic [CHANNELS-1:0] rx_prev;
      logic [CHANNELS*MSR_DELTA_BITS-1:0] delta_prev;
      logic event_out;
   } wake_s;

   wake_s state_q;
   wake_s state_d;
   logic [CHANNELS-1:0] hit;

   // per channel: falling receive line (start bit) or newly set delta bit
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign hit[ch] = (state_q.rx_prev[ch] & ~i_rx[ch]) |
         (|(i_msr_delta[ch*MSR_DELTA_BITS +: MSR_DELTA_BITS] &
            ~state_q.delta_prev[ch*MSR_DELTA_BITS +: MSR_DELTA_BITS]));
   end

   // next state
   always_comb begin
      state_d = state_q;
      state_d.rx_prev = i_rx;
      state_d.delta_prev = i_msr_delta;
      state_d.event_out = |hit;
   end

   // registers; idle line is high, so the reset value avoids a false start
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state_q <= '{rx_prev: '1, delta_prev: '0, event_out: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign o_wake_event = state_q.event_out;
endmodule : wake_detect

// File: test/pm_power_ctrl_chk.sv
`timescale 1ns/1ns
module pm_power_ctrl_chk
   import pm_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int LOAD_LIMIT = LOAD_LIMIT_CYCLES
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // config bus
   input wire logic i_cfg_write,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic i_sw_init_done,
   input wire logic o_cfg_ack,
   // gating and wake
   input wire logic o_mem_respond_en,
   input wire logic o_irq_en,
   input wire logic o_pci_drive_en,
   input wire logic o_rx_enable,
   input wire logic o_d3hot,
   input wire logic o_pme_oe,
   // eeprom loader
   input wire logic o_ee_req,
   input wire logic [2:0] o_ee_addr,
   input wire logic i_ee_valid,
   input wire logic o_load_busy
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   logic pm_wr;
   logic [31:0] ld_cnt_q, ld_cnt_d;
   // acknowledged write to the control/status low byte
   assign pm_wr = o_cfg_ack && i_cfg_write && i_cfg_addr == OFF_PM_CSR && i_cfg_be[0];
   // counts cycles spent loading since reset
   always_comb ld_cnt_d = o_load_busy ? ld_cnt_q + 32'h1 : ld_cnt_q;
   always_ff @(posedge i_clock) begin
      if (i_reset) ld_cnt_q <= 32'h0;
      else ld_cnt_q <= ld_cnt_d;
   end
   // ****************************************************************
   // properties
   // ****************************************************************
   property p_pme_d3; o_pme_oe |-> o_d3hot; endproperty
   a_pme_d3: assert property (p_pme_d3) else $error("wake pin outside D3hot");
   property p_d3_gate; o_d3hot |-> !o_mem_respond_en && !o_irq_en; endproperty
   a_d3_gate: assert property (p_d3_gate) else $error("D3hot not gated");
   property p_rx_on; o_rx_enable && (o_irq_en == o_mem_respond_en); endproperty
   a_rx_on: assert property (p_rx_on) else $error("receive or irq gating wrong");
   property p_d3_in; pm_wr && i_cfg_wdata[1:0] == PS_D3HOT |-> o_d3hot; endproperty
   a_d3_in: assert property (p_d3_in) else $error("D3hot write not taken");
   property p_bad_code;
      pm_wr && (i_cfg_wdata[1:0] == 2'h1 || i_cfg_wdata[1:0] == 2'h2) |-> o_d3hot == $past(o_d3hot);
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("bad state code acted on");
   property p_back;
      pm_wr && i_cfg_wdata[1:0] == PS_D0 && $past(o_d3hot) && i_sw_init_done
      |-> !o_pci_drive_en && !o_d3hot ##1 o_pci_drive_en && o_mem_respond_en;
   endproperty
   a_back: assert property (p_back) else $error("D3hot to D0 return wrong");
   property p_rst; $fell(i_reset) |-> o_load_busy && !o_d3hot && !o_pme_oe && o_pci_drive_en;
   endproperty
   a_rst: assert property (p_rst) else $error("reset defaults wrong");
   property p_bound; ld_cnt_q <= 32'(LOAD_LIMIT + 2); endproperty
   a_bound: assert property (p_bound) else $error("download too long");
   property p_step;
      o_ee_req && i_ee_valid && o_ee_addr != 3'h7 |=> o_ee_req && o_ee_addr == $past(o_ee_addr) + 3'h1;
   endproperty
   a_step: assert property (p_step) else $error("eeprom word order wrong");
   property p_end; o_ee_req && i_ee_valid && o_ee_addr == 3'h7 |=> !o_ee_req && !o_load_busy;
   endproperty
   a_end: assert property (p_end) else $error("download did not end");
endmodule : pm_power_ctrl_chk
bind pm_power_ctrl pm_power_ctrl_chk #(.CHANNELS(CHANNELS), .LOAD_LIMIT(LOAD_LIMIT)) chk (
   .i_clock(i_clock), .i_reset(i_reset), .i_cfg_write(i_cfg_write), .i_cfg_addr(i_cfg_addr),
   .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata), .i_sw_init_done(i_sw_init_done),
   .o_cfg_ack(o_cfg_ack), .o_mem_respond_en(o_mem_respond_en), .o_irq_en(o_irq_en),
   .o_pci_drive_en(o_pci_drive_en), .o_rx_enable(o_rx_enable), .o_d3hot(o_d3hot),
   .o_pme_oe(o_pme_oe), .o_ee_req(o_ee_req), .o_ee_addr(o_ee_addr), .i_ee_valid(i_ee_valid),
   .o_load_busy(o_load_busy));

// File: test/ee_word_model.sv
`timescale 1ns/1ns
module ee_word_model (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // word request and answer
   input wire logic i_req,
   input wire logic [2:0] i_addr,
   input wire logic [3:0] i_delay,
   output logic o_valid,
   output logic [15:0] o_data
);
   logic [3:0] cnt;
   // answers each requested 16-bit word after i_delay idle cycles
   always @(posedge i_clock) begin
      if (i_reset || !i_req || o_valid) begin
         o_valid <= 1'b0;
         cnt <= 4'h0;
         o_data <= ~o_data; // stale data never holds
      end else if (cnt == i_delay) begin
         o_valid <= 1'b1;
         o_data <= {1'b0, i_addr, 4'hA, 1'b0, i_addr, 4'h5};
      end else begin
         cnt <= cnt + 4'h1;
         o_data <= ~o_data;
      end
   end
endmodule : ee_word_model

// File: test/pm_power_ctrl_bench.sv
`timescale 1ns/1ns
module pm_power_ctrl_bench;
   import pm_pkg::*;
   localparam int LIM = 64;
   localparam logic [7:0] REV = 8'h3C; // arbitrary value
   localparam logic [15:0] VEN = 16'h2B4D; // arbitrary value
   localparam logic [15:0] DEV = 16'h6E71; // arbitrary value
   logic i_clock, i_reset, req, wr, sw_init, cs, ee_valid, ack, mem_en, irq_en, drive_en;
   logic rx_en, d3hot, pme_out, pme_oe, ee_req, busy;
   logic [7:0] addr, rx;
   logic [3:0] be, dly;
   logic [31:0] wdata, rdata, rd, delta;
   logic [15:0] ee_data;
   logic [2:0] ee_addr;
   int n_fail = 0;
   int tests_run = 0;
   pm_power_ctrl #(.LOAD_LIMIT(LIM), .REVISION(REV), .VENDOR_DEFAULT(VEN),
      .DEVICE_DEFAULT(DEV)) uut (.i_clock(i_clock), .i_reset(i_reset),
      .i_cfg_req(req), .i_cfg_write(wr), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata),
      .o_cfg_ack(ack), .o_cfg_rdata(rdata), .i_sw_init_done(sw_init), .o_mem_respond_en(mem_en),
      .o_irq_en(irq_en), .o_pci_drive_en(drive_en), .o_rx_enable(rx_en), .o_d3hot(d3hot),
      .i_rx(rx), .i_msr_delta(delta), .o_pme_out(pme_out), .o_pme_oe(pme_oe),
      .i_eeprom_chip_select(cs), .o_ee_req(ee_req), .o_ee_addr(ee_addr), .i_ee_valid(ee_valid),
      .i_ee_data(ee_data), .o_load_busy(busy));
   ee_word_model ee (.i_clock(i_clock), .i_reset(i_reset), .i_req(ee_req), .i_addr(ee_addr),
      .i_delay(dly), .o_valid(ee_valid), .o_data(ee_data));
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   function automatic logic [15:0] ew(input logic [2:0] a);
      return {1'b0, a, 4'hA, 1'b0, a, 4'h5};
   endfunction : ew
   task automatic close_out();
      if (n_fail == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_up();
      n_fail++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
   endtask : give_up
   task automatic do_reset(input logic strap, input logic [3:0] d, output int cyc);
      @(posedge i_clock);
      i_reset <= 1'b1;
      cs <= strap;
      dly <= d;
      sw_init <= 1'b0;
      repeat (20) @(posedge i_clock);
      i_reset <= 1'b0;
      for (cyc = 0; cyc < 400 && busy !== 1'b0; cyc++) @(posedge i_clock);
      if (cyc == 400) give_up();
   endtask : do_reset
   task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
      int i;
      @(posedge i_clock);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      be <= b;
      wdata <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge i_clock);
         if (ack === 1'b1) break;
      end
      rd = rdata;
      req <= 1'b0;
      if (i == 50) give_up();
   endtask : cfg
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_download();
      int c;
      logic [15:0] w2;
      w2 = ew(3'h2);
      for (int k = 0; k < 2; k++) begin
         do_reset(1'b1, 4'(k * 3), c);
         cfg(1'b0, OFF_ID, 4'hF, 32'h0);
         check(rd, {ew(3'h1), ew(3'h0)});
         cfg(1'b0, OFF_CLASS, 4'hF, 32'h0);
         check(rd, {ew(3'h3), w2[15:8], REV});
         cfg(1'b0, OFF_SUBSYS, 4'hF, 32'h0);
         check(rd, {ew(3'h5), ew(3'h4)});
      end
      cfg(1'b1, OFF_USER, 4'hF, 32'h0);
      cfg(1'b0, OFF_USER, 4'hF, 32'h0);
      check(rd, {ew(3'h7), ew(3'h6)});
   endtask : t_download
   task automatic t_timeout();
      int c;
      do_reset(1'b1, 4'hF, c);
      check(32'(c <= LIM + 2), 32'h1);
      cfg(1'b0, OFF_USER, 4'hF, 32'h0);
      check(rd, 32'h0);
   endtask : t_timeout
   task automatic t_no_strap();
      int c;
      do_reset(1'b0, 4'h0, c);
      cfg(1'b0, OFF_ID, 4'hF, 32'h0);
      check(rd, {DEV, VEN});
      cfg(1'b0, OFF_USER, 4'hF, 32'h0);
      check(rd, 32'h0);
      check(mem_en, 1'b0);
      cfg(1'b1, OFF_PM_CSR, 4'h1, 32'hFC);
      cfg(1'b0, OFF_PM_CSR, 4'hF, 32'h0);
      check(rd, 32'h0);
      for (int k = 1; k < 3; k++) begin
         cfg(1'b1, OFF_PM_CSR, 4'h1, 32'(k));
         check(d3hot, 1'b0);
      end
   endtask : t_no_strap
   task automatic t_power();
      int c;
      do_reset(1'b0, 4'h0, c);
      sw_init <= 1'b1;
      repeat (3) @(posedge i_clock);
      check({irq_en, mem_en}, 2'h3);
      // sleep mode is requested from D0 active; the clear-by-one write below repeats the D3hot code while in D3hot
      cfg(1'b1, OFF_PM_CSR, 4'h1, 32'h3);
      check({d3hot, irq_en, mem_en}, 3'h4);
      check(rx_en, 1'b1);
      delta[31] <= 1'b1;
      repeat (3) @(posedge i_clock);
      check(pme_oe, 1'b0);
      delta <= 32'h0;
      cfg(1'b0, OFF_PM_CSR, 4'hF, 32'h0);
      check(rd, 32'h8003);
      cfg(1'b1, OFF_PM_CSR, 4'h3, 32'h8103); // host clears by one
      cfg(1'b0, OFF_PM_CSR, 4'hF, 32'h0);
      check(rd, 32'h0103);
      rx[0] <= 1'b0;
      for (c = 0; c < 5 && pme_oe !== 1'b1; c++) @(posedge i_clock);
      check(pme_oe, 1'b1);
      check(pme_out, 1'b0);
      rx <= 8'hFF;
      cfg(1'b1, OFF_PM_CSR, 4'h1, 32'h0);
      check({drive_en, d3hot}, 2'h0);
      @(posedge i_clock);
      check({drive_en, mem_en, pme_oe}, 3'h6);
      cfg(1'b0, OFF_PM_CSR, 4'hF, 32'h0);
      check(rd, 32'h8100);
      cfg(1'b1, OFF_PM_CSR, 4'h1, 32'h3);
      do_reset(1'b0, 4'h0, c); // host resets after power returns
      cfg(1'b0, OFF_PM_CSR, 4'hF, 32'h0);
      check(rd, 32'h0);
      check(d3hot, 1'b0);
   endtask : t_power
   initial begin
      i_reset = 1'b1;
      req = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      be = 4'h0;
      wdata = 32'h0;
      sw_init = 1'b0;
      cs = 1'b1;
      rx = 8'hFF;
      delta = 32'h0;
      dly = 4'h0;
      t_download();
      t_timeout();
      t_no_strap();
      t_power();
      close_out();
   end
endmodule : pm_power_ctrl_bench
